// ===== pscg_pkg.sv
// pscg_pkg: constants for the power-save clock gating block
// assumes a 250 MHz system clock and a plain strobe register port
package pscg_pkg;
  // register offsets (word index on the register port)
  localparam logic [3:0]  ADDR_DIV_CTRL  = 4'h0;
  localparam logic [3:0]  ADDR_GATE1     = 4'h1;
  localparam logic [3:0]  ADDR_PWR_CTRL  = 4'h2;
  localparam logic [3:0]  ADDR_PWR_STAT  = 4'h3;
  // clock divider control fields
  localparam int          RECOVER_BIT    = 15;
  localparam int          RATIO_HI       = 14;
  localparam int          RATIO_LO       = 12;
  localparam int          SLOW_EN_BIT    = 11;
  localparam logic [15:0] DIV_CTRL_MASK  = 16'hF800;
  localparam logic [15:0] DIV_CTRL_RESET = 16'h0000;
  // module gate register 1: implemented bits
  localparam int          ADC_BIT        = 0;
  localparam int          SPI_BIT        = 3;
  localparam int          UART_BIT       = 5;
  localparam int          I2C_BIT        = 7;
  localparam int          PWM_BIT        = 9;
  localparam int          TMR1_BIT       = 11;
  localparam int          TMR2_BIT       = 12;
  localparam int          TMR3_BIT       = 13;
  localparam logic [15:0] GATE1_MASK     = 16'h3AA9;
  localparam logic [15:0] GATE1_RESET    = 16'h0000;
  // power control: watchdog and clock monitor enables
  localparam int          WDT_EN_BIT     = 0;
  localparam int          MONITOR_EN_BIT = 1;
  localparam logic [15:0] PWR_CTRL_MASK  = 16'h0003;
  localparam logic [15:0] PWR_CTRL_RESET = 16'h0000;
  // power-save instruction operands
  localparam logic [1:0]  MODE_SLEEP     = 2'h0;
  localparam logic [1:0]  MODE_IDLE      = 2'h1;
  // wake to resume: 2 to 4 cycles allowed, we take 3
  localparam int          WAKE_MIN_CYC   = 2;
  localparam int          WAKE_MAX_CYC   = 4;
  localparam logic [2:0]  WAKE_CYC       = 3'h3;
  // module gate change delay: one instruction cycle
  localparam int          GATE_DLY_CYC   = 1;
  typedef enum logic [1:0] {
    PS_RUN   = 2'b00,
    PS_IDLE  = 2'b01,
    PS_SLEEP = 2'b10,
    PS_WAKE  = 2'b11
  } pscg_state_type;
endpackage

// ===== pscg_doze_div.sv
// pscg_doze_div: cpu clock enable divider for doze operation
// assumes one system clock; ratio is a power-of-two exponent
`timescale 1ns/1ns
module pscg_doze_div (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  // control
  input  wire logic       slow_in,
  input  wire logic [2:0] ratio_in,
  // enable pulse
  output logic            cpu_en_out
);
  logic [6:0] count;
  logic [6:0] next_count;
  logic [6:0] limit;
  logic       next_en;

  // ratio n divides by 2**n, 0 means 1:1
  always_comb begin
    limit = 7'((8'h01 << ratio_in) - 8'h01);
    next_count = 7'h00;
    next_en = 1'b1;
    if (slow_in && (limit != 7'h00)) begin
      next_en = (count == limit);
      next_count = (count == limit) ? 7'h00 : 7'(count + 7'h01);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= 7'h00;
      cpu_en_out <= 1'b1;
    end else begin
      count <= next_count;
      cpu_en_out <= next_en;
    end
  end
endmodule

// ===== pscg_top.sv
// pscg_top: idle/sleep entry, doze clock slowing and module clock gates
// assumes registers reached by a plain strobe port and a core that
// issues the power-save instruction as a one-cycle pulse with operand
//
// How it works
// RULE1 - only the power-save instruction enters low power
// RULE2 - idle halts cpu instruction execution
// RULE3 - idle entry clears the watchdog counter
// RULE4 - idle keeps system and peripheral clocks
// RULE5 - rc oscillator runs if watchdog/monitor on (here the monitor keeps it running only outside sleep)
// RULE6 - enabled interrupt, reset or timeout wakes
// RULE7 - cpu resumes two to four cycles after wake
// RULE8 - peripherals may stop in idle
// RULE9 - interrupt during entry waits, then wakes
// RULE10 - doze slows only cpu, domains stay aligned
// RULE11 - bit 11 enables doze
// RULE12 - bits 14:12 pick ratio, default 1:1
// RULE13 - bit 15 makes interrupts restore full speed
// RULE14 - gate bit stops all module clocks
// RULE15 - gated module ignores writes, reads invalid
// RULE16 - module on if bit clear and present
// RULE17 - gate change lands one instruction later
// RULE18 - gate bit positions for eight modules
// RULE19 - unimplemented gate bits read zero
// RULE20 - ratio codes are powers of two
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module pscg_top #(
  parameter logic [15:0] PRESENT_MASK = 16'h3AA9
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  // register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [15:0]      reg_rdata_out,
  // core side
  input  wire logic        pwrsave_in,
  input  wire logic [1:0]  pwrsave_mode_in,
  input  wire logic        irq_pending_in,
  input  wire logic        wdt_timeout_in,
  input  wire logic [15:0] stop_in_idle_in,
  output logic             cpu_clk_en_out,
  output logic             cpu_halt_out,
  output logic             wdt_clear_out,
  output logic             sys_osc_en_out,
  output logic             rc_osc_en_out,
  output logic [1:0]       pwr_state_out,
  // per-module clock enables
  output logic [15:0]      periph_clk_en_out,
  output logic [15:0]      periph_access_en_out
);
  pscg_pkg::pscg_state_type state;
  pscg_pkg::pscg_state_type next_state;
  logic [15:0] clock_divider_control;
  logic [15:0] next_clock_divider_control;
  logic [15:0] gate1;
  logic [15:0] next_gate1;
  logic [15:0] pwr_ctrl;
  logic [15:0] next_pwr_ctrl;
  logic [15:0] gate_dly;
  logic [15:0] next_gate_dly;
  logic [2:0]  wake_cnt;
  logic [2:0]  next_wake_cnt;
  logic        recovered_fast;
  logic        next_recovered_fast;
  logic        irq_held;
  logic        next_irq_held;
  logic [15:0] next_rdata;
  logic        div_en;
  logic        low_power;
  logic [15:0] next_clk_en;
  logic [15:0] next_acc_en;
  logic        wdt_on;
  logic        monitor_on;

  assign wdt_on = pwr_ctrl[pscg_pkg::WDT_EN_BIT];
  assign monitor_on = pwr_ctrl[pscg_pkg::MONITOR_EN_BIT];
  assign low_power = (state == pscg_pkg::PS_IDLE) || (state == pscg_pkg::PS_SLEEP);

  // register writes
  always_comb begin
    next_clock_divider_control = clock_divider_control;
    next_gate1 = gate1;
    next_pwr_ctrl = pwr_ctrl;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        pscg_pkg::ADDR_DIV_CTRL: begin
          next_clock_divider_control = reg_wdata_in & pscg_pkg::DIV_CTRL_MASK; // RULE11 RULE12 RULE13
        end
        pscg_pkg::ADDR_GATE1: begin
          next_gate1 = reg_wdata_in & pscg_pkg::GATE1_MASK; // RULE18 RULE19
        end
        pscg_pkg::ADDR_PWR_CTRL: begin
          next_pwr_ctrl = reg_wdata_in & pscg_pkg::PWR_CTRL_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        pscg_pkg::ADDR_DIV_CTRL: next_rdata = clock_divider_control;
        pscg_pkg::ADDR_GATE1:    next_rdata = gate1; // RULE19
        pscg_pkg::ADDR_PWR_CTRL: next_rdata = pwr_ctrl;
        pscg_pkg::ADDR_PWR_STAT: next_rdata = {13'h0000, recovered_fast, 2'(state)};
        default:                 next_rdata = 16'h0000;
      endcase
    end
  end

  // low-power state machine
  always_comb begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    next_irq_held = 1'b0;
    unique case (state)
      pscg_pkg::PS_RUN: begin
        if (pwrsave_in) begin // RULE1
          next_state = (pwrsave_mode_in == pscg_pkg::MODE_IDLE) ?
                       pscg_pkg::PS_IDLE : pscg_pkg::PS_SLEEP;
          // interrupt coincident with entry is held, then wakes
          next_irq_held = irq_pending_in; // RULE9
        end
      end
      pscg_pkg::PS_IDLE, pscg_pkg::PS_SLEEP: begin
        if (irq_pending_in || wdt_timeout_in || irq_held) begin // RULE6 RULE9
          next_state = pscg_pkg::PS_WAKE;
          next_wake_cnt = pscg_pkg::WAKE_CYC; // RULE7
        end
      end
      pscg_pkg::PS_WAKE: begin
        next_wake_cnt = 3'(wake_cnt - 3'h1);
        if (wake_cnt == 3'h1) begin
          next_state = pscg_pkg::PS_RUN;
        end
      end
    endcase
  end

  // doze interrupt recovery: interrupt returns full speed while recover bit set
  always_comb begin
    next_recovered_fast = recovered_fast;
    if (!clock_divider_control[pscg_pkg::SLOW_EN_BIT] || !clock_divider_control[pscg_pkg::RECOVER_BIT]) begin
      next_recovered_fast = 1'b0;
    end else if (irq_pending_in) begin
      next_recovered_fast = 1'b1; // RULE13
    end
  end

  // gate bits applied one cycle late; idle stop-in-idle per module
  always_comb begin
    next_gate_dly = gate1; // RULE17
    next_clk_en = ~gate_dly & PRESENT_MASK; // RULE14 RULE16
    if (state == pscg_pkg::PS_IDLE) begin
      next_clk_en = next_clk_en & ~stop_in_idle_in; // RULE4 RULE8
    end else if (state == pscg_pkg::PS_SLEEP) begin
      next_clk_en = 16'h0000;
    end
    next_acc_en = ~gate_dly & PRESENT_MASK; // RULE15
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= pscg_pkg::PS_RUN;
      clock_divider_control <= pscg_pkg::DIV_CTRL_RESET;
      gate1 <= pscg_pkg::GATE1_RESET;
      pwr_ctrl <= pscg_pkg::PWR_CTRL_RESET;
      gate_dly <= pscg_pkg::GATE1_RESET;
      wake_cnt <= 3'h0;
      recovered_fast <= 1'b0;
      irq_held <= 1'b0;
      reg_rdata_out <= 16'h0000;
      cpu_clk_en_out <= 1'b1;
      cpu_halt_out <= 1'b0;
      wdt_clear_out <= 1'b0;
      sys_osc_en_out <= 1'b1;
      rc_osc_en_out <= 1'b0;
      pwr_state_out <= 2'h0;
      periph_clk_en_out <= 16'h0000;
      periph_access_en_out <= 16'h0000;
    end else begin
      state <= next_state;
      clock_divider_control <= next_clock_divider_control;
      gate1 <= next_gate1;
      pwr_ctrl <= next_pwr_ctrl;
      gate_dly <= next_gate_dly;
      wake_cnt <= next_wake_cnt;
      recovered_fast <= next_recovered_fast;
      irq_held <= next_irq_held;
      reg_rdata_out <= next_rdata;
      // cpu held while low power or waking
      cpu_clk_en_out <= (next_state == pscg_pkg::PS_RUN) && div_en; // RULE2 RULE10
      cpu_halt_out <= (next_state != pscg_pkg::PS_RUN); // RULE2
      wdt_clear_out <= (state == pscg_pkg::PS_RUN) && pwrsave_in; // RULE3
      sys_osc_en_out <= (next_state != pscg_pkg::PS_SLEEP); // RULE4
      rc_osc_en_out <= wdt_on || (monitor_on && (next_state != pscg_pkg::PS_SLEEP)); // RULE5
      pwr_state_out <= 2'(next_state);
      periph_clk_en_out <= next_clk_en;
      periph_access_en_out <= next_acc_en;
    end
  end

  // divider counts system clocks, so cpu edges stay aligned to them
  pscg_doze_div u_div (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .slow_in    (clock_divider_control[pscg_pkg::SLOW_EN_BIT] && !recovered_fast), // RULE10 RULE11
    .ratio_in   (clock_divider_control[pscg_pkg::RATIO_HI:pscg_pkg::RATIO_LO]), // RULE12 RULE20
    .cpu_en_out (div_en)
  );

  // assertions
  sequence s_enter_idle;
    state == pscg_pkg::PS_RUN && pwrsave_in && pwrsave_mode_in == pscg_pkg::MODE_IDLE;
  endsequence

  chk_idle_entry: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE1
    s_enter_idle |=> state == pscg_pkg::PS_IDLE)
    else $error("idle not entered");
  chk_no_spurious: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE1
    state == pscg_pkg::PS_RUN && !pwrsave_in |=> state != pscg_pkg::PS_IDLE)
    else $error("idle without instruction");
  chk_halt_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE2
    state == pscg_pkg::PS_IDLE |-> cpu_halt_out && !cpu_clk_en_out)
    else $error("cpu runs in idle");
  chk_wdt_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE3
    s_enter_idle |=> wdt_clear_out)
    else $error("watchdog not cleared");
  chk_osc_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE4
    state == pscg_pkg::PS_IDLE |-> sys_osc_en_out)
    else $error("oscillator off in idle");
  chk_wake_time: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE7
    (state == pscg_pkg::PS_IDLE && (irq_pending_in || wdt_timeout_in))
      |-> ##[2:4] !cpu_halt_out)
    else $error("resume outside window");
  chk_held_irq: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE9
    (state == pscg_pkg::PS_RUN && pwrsave_in && irq_pending_in)
      |=> state != pscg_pkg::PS_RUN ##1 state == pscg_pkg::PS_WAKE)
    else $error("held interrupt lost");
  chk_gate_delay: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE17
    $rose(gate1[pscg_pkg::TMR1_BIT]) && PRESENT_MASK[pscg_pkg::TMR1_BIT]
      |=> periph_access_en_out[pscg_pkg::TMR1_BIT] ##1 !periph_access_en_out[pscg_pkg::TMR1_BIT])
    else $error("gate delay wrong");
  chk_unimpl_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE19
    (gate1 & ~pscg_pkg::GATE1_MASK) == 16'h0000)
    else $error("unimplemented bit set");
endmodule

// ===== pscg_core_model.sv
// pscg_core_model: processor core stand-in that counts executed cycles
// assumes cpu clock enable and halt come from the clock gating block
`timescale 1ns/1ns
module pscg_core_model (
  // clock and reset
  input  wire logic   sys_clk_in,
  input  wire logic   rst_b_in,
  // from the gating block
  input  wire logic   cpu_clk_en_in,
  input  wire logic   cpu_halt_in,
  // executed cycle count
  output logic [15:0] exec_count_out
);
  logic [15:0] next_exec_count;
  always_comb begin
    next_exec_count = exec_count_out;
    // a core only advances on an enabled, unhalted cycle
    if (cpu_clk_en_in && !cpu_halt_in) begin
      next_exec_count = exec_count_out + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      exec_count_out <= 16'h0000;
    end else begin
      exec_count_out <= next_exec_count;
    end
  end
endmodule

// ===== tb_power_save_clock_gating.sv
// tb_power_save_clock_gating: self-checking bench for pscg_top
// assumes the design package and the core model are compiled first
`timescale 1ns/1ns
module tb_power_save_clock_gating;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        psv = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic        irq = 1'b0;
  logic        wto = 1'b0;
  logic [15:0] sidl = 16'h0000;
  logic [15:0] rdata, clk_en, acc_en, cnt, c0;
  logic        cpu_en, halt, wclr, osc, rcosc;
  logic [1:0]  st;
  int          bad_count = 0;
  int          cmp_count = 0;
  always #2 clk = ~clk;
  pscg_top DUT (.sys_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .pwrsave_in(psv), .pwrsave_mode_in(mode), .irq_pending_in(irq),
    .wdt_timeout_in(wto), .stop_in_idle_in(sidl), .cpu_clk_en_out(cpu_en),
    .cpu_halt_out(halt), .wdt_clear_out(wclr), .sys_osc_en_out(osc),
    .rc_osc_en_out(rcosc), .pwr_state_out(st), .periph_clk_en_out(clk_en),
    .periph_access_en_out(acc_en));
  pscg_core_model core (.sys_clk_in(clk), .rst_b_in(rst_b), .cpu_clk_en_in(cpu_en),
    .cpu_halt_in(halt), .exec_count_out(cnt));
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic enter(input logic [1:0] m, input logic with_irq);
    @(posedge clk);
    psv <= 1'b1;
    mode <= m;
    irq <= with_irq;
    @(posedge clk);
    psv <= 1'b0;
    #1;
  endtask
  // edges counted until halt drops; bounded so a stuck wake ends the run
  task automatic wake(input int lo, input int hi);
    int i;
    for (i = 1; i <= 8; i++) begin
      @(posedge clk);
      #1;
      if (halt === 1'b0) break;
    end
    chk({15'h0000, i >= lo && i <= hi}, 16'h0001);
    chk({14'h0000, st}, {14'h0000, pscg_pkg::PS_RUN});
    if (i > 8) begin
      bad_count++;
      results();
    end
  endtask
  task automatic t_reset();
    chk({14'h0000, st}, {14'h0000, pscg_pkg::PS_RUN});
    chk(clk_en, 16'h3AA9);
    chk({13'h0000, osc, rcosc, halt}, 16'h0004);
    rreg(pscg_pkg::ADDR_DIV_CTRL, 16'h0000);
    rreg(pscg_pkg::ADDR_GATE1, 16'h0000);
    rreg(4'hF, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_gate();
    for (int b = 0; b < 16; b++) begin
      wreg(pscg_pkg::ADDR_GATE1, 16'h0001 << b);
      tick(3);
      chk(clk_en, 16'h3AA9 & ~(16'h0001 << b));
      chk(acc_en, 16'h3AA9 & ~(16'h0001 << b));
      rreg(pscg_pkg::ADDR_GATE1, 16'h3AA9 & (16'h0001 << b));
    end
    // gate lands two edges after the write edge, not before
    wreg(pscg_pkg::ADDR_GATE1, 16'h0001);
    tick(1);
    chk(clk_en, 16'h3AA9);
    tick(1);
    chk(clk_en, 16'h3AA8);
    wreg(pscg_pkg::ADDR_GATE1, 16'h0000);
    tick(3);
    chk(clk_en, 16'h3AA9);
    $display("gate test done");
  endtask
  task automatic t_idle();
    wreg(pscg_pkg::ADDR_PWR_CTRL, 16'h0001);
    sidl <= 16'h0001;
    enter(pscg_pkg::MODE_IDLE, 1'b0);
    chk({12'h000, st, halt, cpu_en}, 16'h0006);
    chk({13'h0000, wclr, osc, rcosc}, 16'h0007);
    c0 = cnt;
    tick(4);
    chk(clk_en, 16'h3AA8);
    chk(cnt, c0);
    @(posedge clk);
    irq <= 1'b1;
    wake(3, 5);
    irq <= 1'b0;
    sidl <= 16'h0000;
    enter(pscg_pkg::MODE_IDLE, 1'b1);
    chk({14'h0000, st}, {14'h0000, pscg_pkg::PS_IDLE});
    wake(1, 5);
    irq <= 1'b0;
    $display("idle test done");
  endtask
  task automatic t_sleep();
    wreg(pscg_pkg::ADDR_PWR_CTRL, 16'h0002);
    enter(pscg_pkg::MODE_SLEEP, 1'b0);
    chk({13'h0000, st, osc}, 16'h0004);
    chk({15'h0000, rcosc}, 16'h0000);
    @(posedge clk);
    wto <= 1'b1;
    @(posedge clk);
    wto <= 1'b0;
    wake(2, 4);
    $display("sleep test done");
  endtask
  task automatic t_doze();
    for (int r = 0; r < 8; r++) begin
      wreg(pscg_pkg::ADDR_DIV_CTRL, 16'h0800 | (r << 12));
      rreg(pscg_pkg::ADDR_DIV_CTRL, 16'h0800 | (r << 12));
      c0 = cnt;
      tick(256);
      chk(cnt - c0, 16'h0100 >> r);
    end
    for (int k = 0; k < 2; k++) begin
      wreg(pscg_pkg::ADDR_DIV_CTRL, k == 0 ? 16'hF800 : 16'h7800);
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      tick(4);
      rreg(pscg_pkg::ADDR_PWR_STAT, k == 0 ? 16'h0004 : 16'h0000);
      c0 = cnt;
      tick(256);
      chk(cnt - c0, k == 0 ? 16'h0100 : 16'h0002);
    end
    wreg(pscg_pkg::ADDR_DIV_CTRL, 16'h0000);
    $display("doze test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    tick(2);
    t_reset();
    t_gate();
    t_idle();
    t_sleep();
    t_doze();
    results();
  end
endmodule
